// ### verilog/sfpl_pkg.sv
// constants and carrier types shared by the status word and page latch block
package sfpl_pkg;
	// upper status byte bit positions
	localparam int unsigned UPPER_SENSE_POS = 7;
	localparam int unsigned UPPER_FLAG_POS = 6;
	localparam int unsigned UPPER_BLOCK_POS = 5;
	// lower status byte bit positions
	localparam int unsigned LOWER_CC_HI_POS = 7;
	localparam int unsigned LOWER_CC_LO_POS = 6;
	localparam int unsigned LOWER_HALF_POS = 5;
	localparam int unsigned LOWER_BANK_POS = 4;
	localparam int unsigned LOWER_WC_POS = 3;
	localparam int unsigned LOWER_OVF_POS = 2;
	localparam int unsigned LOWER_CMP_POS = 1;
	localparam int unsigned LOWER_CARRY_POS = 0;
	// writable bits of the upper byte: flag, block, level counter
	localparam logic [7:0] UPPER_WRITE_MASK = 8'h67;
	localparam logic [7:0] UPPER_RESET = 8'h00;
	localparam logic [7:0] LOWER_RESET = 8'h00;
	localparam logic [1:0] PAGE_RESET = 2'h0;
	localparam logic [1:0] PAGE_ZERO = 2'h0;
	localparam logic [1:0] CC_POSITIVE = 2'h1;
	localparam logic [1:0] CC_ZERO = 2'h0;
	localparam logic [1:0] CC_NEGATIVE = 2'h2;
	localparam int unsigned OFFSET_BITS = 13;
	localparam int unsigned PAGE_BITS = 2;
	localparam int unsigned FULL_ADDR_BITS = 15;
	localparam int unsigned PAGE_BYTES = 8192;

	typedef enum logic [3:0] {
		SFPL_OP_NONE = 4'h0,
		SFPL_OP_LOAD = 4'h1,
		SFPL_OP_ADD = 4'h2,
		SFPL_OP_SUB = 4'h3,
		SFPL_OP_CMP = 4'h4,
		SFPL_OP_ROR = 4'h5,
		SFPL_OP_ROL = 4'h6
	} sfpl_alu_op_type;

	typedef enum logic [2:0] {
		SFPL_PSW_NONE = 3'h0,
		SFPL_PSW_LOAD = 3'h1,
		SFPL_PSW_PRESET = 3'h2,
		SFPL_PSW_CLEAR = 3'h3
	} sfpl_psw_op_type;

	typedef struct packed {
		sfpl_alu_op_type op;
		logic [7:0] a;
		logic [7:0] b;
	} sfpl_alu_req_type;

	typedef struct packed {
		logic [7:0] result;
		logic carry;
		logic half;
		logic ovf;
		logic [1:0] cc;
	} sfpl_alu_res_type;

	typedef struct packed {
		logic [1:0] page;
		logic [12:0] offset;
	} sfpl_addr_type;
endpackage : sfpl_pkg

// ### verilog/sfpl_alu.sv
// combinational arithmetic core deriving result, carries, overflow and condition code
`timescale 1ns/100ps
module sfpl_alu (
	input wire sfpl_pkg::sfpl_alu_req_type req_in,
	input wire logic carry_in,
	input wire logic carry_use_in,
	input wire logic unsigned_cmp_in,
	output sfpl_pkg::sfpl_alu_res_type res_out
);
	logic [8:0] full;
	logic [4:0] low;
	logic cin;
	logic lt;
	logic eq;

	always_comb
	begin
		res_out = '0;
		full = 9'h000;
		low = 5'h00;
		lt = 1'b0;
		eq = 1'b0;
		cin = carry_use_in & carry_in;
		case (req_in.op)
			sfpl_pkg::SFPL_OP_ADD:
			begin
				full = {1'b0, req_in.a} + {1'b0, req_in.b} + {8'h00, cin};
				low = {1'b0, req_in.a[3:0]} + {1'b0, req_in.b[3:0]} + {4'h0, cin};
				res_out.result = full[7:0];
				res_out.carry = full[8];
				res_out.half = low[4];
				res_out.ovf = (req_in.a[7] == req_in.b[7]) && (full[7] != req_in.a[7]);
			end
			sfpl_pkg::SFPL_OP_SUB:
			begin
				// clear carry means pending borrow when carry is used
				full = {1'b0, req_in.a} + {1'b0, ~req_in.b} + {8'h00, ~carry_use_in | carry_in};
				low = {1'b0, req_in.a[3:0]} + {1'b0, ~req_in.b[3:0]}
					+ {4'h0, ~carry_use_in | carry_in};
				res_out.result = full[7:0];
				res_out.carry = full[8];
				res_out.half = low[4];
				res_out.ovf = (req_in.a[7] != req_in.b[7]) && (full[7] != req_in.a[7]);
			end
			sfpl_pkg::SFPL_OP_CMP:
			begin
				eq = req_in.a == req_in.b;
				lt = unsigned_cmp_in ? (req_in.a < req_in.b)
					: ($signed(req_in.a) < $signed(req_in.b));
			end
			sfpl_pkg::SFPL_OP_ROR:
			begin
				res_out.result = {carry_use_in ? carry_in : req_in.a[0], req_in.a[7:1]};
				res_out.carry = carry_use_in ? req_in.a[0] : carry_in;
			end
			sfpl_pkg::SFPL_OP_ROL:
			begin
				res_out.result = {req_in.a[6:0], carry_use_in ? carry_in : req_in.a[7]};
				res_out.carry = carry_use_in ? req_in.a[7] : carry_in;
			end
			default:
			begin
				res_out.result = req_in.a;
			end
		endcase
		if (req_in.op == sfpl_pkg::SFPL_OP_ROR || req_in.op == sfpl_pkg::SFPL_OP_ROL)
		begin
			res_out.half = res_out.result[5];
			res_out.ovf = res_out.result[7] != req_in.a[7];
		end
		// never yields 11 here; only explicit status loads can
		if (req_in.op == sfpl_pkg::SFPL_OP_CMP)
			res_out.cc = eq ? sfpl_pkg::CC_ZERO
				: (lt ? sfpl_pkg::CC_NEGATIVE : sfpl_pkg::CC_POSITIVE);
		else
			res_out.cc = (res_out.result == 8'h00) ? sfpl_pkg::CC_ZERO
				: (res_out.result[7] ? sfpl_pkg::CC_NEGATIVE : sfpl_pkg::CC_POSITIVE);
	end
endmodule : sfpl_alu

// ### verilog/sfpl_addr_mux.sv
// page latch and address line driver for the paged memory space
`timescale 1ns/100ps
module sfpl_addr_mux (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [14:0] addr_in,
	input wire logic addr_valid_in,
	input wire logic branch_in,
	input wire logic indirect_in,
	input wire logic int_service_in,
	output sfpl_pkg::sfpl_addr_type addr_out,
	output logic [1:0] page_latch_out
);
	typedef struct packed {
		logic [1:0] page;
		sfpl_pkg::sfpl_addr_type bus;
	} sfpl_page_state_type;

	sfpl_page_state_type state_q;
	sfpl_page_state_type state_d;

	always_comb
	begin
		state_d = state_q;
		if (int_service_in)
			state_d.page = sfpl_pkg::PAGE_ZERO;
		else if (addr_valid_in && branch_in)
			state_d.page = addr_in[14:13];
		if (addr_valid_in)
		begin
			state_d.bus.offset = addr_in[12:0];
			// an indirect operand borrows the page lines for one access only
			state_d.bus.page = (branch_in || indirect_in) ? addr_in[14:13]
				: state_d.page;
		end
		else
			state_d.bus.page = state_d.page;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			state_q <= {sfpl_pkg::PAGE_RESET, sfpl_pkg::PAGE_RESET, 13'h0000};
		else
			state_q <= state_d;
	end

	assign addr_out = state_q.bus;
	assign page_latch_out = state_q.page;
endmodule : sfpl_addr_mux

// ### verilog/sfpl_status.sv
// status word, flag updates and page addressing of the processor core
// What this block does
// - sense bit shows the sense pin two sync flops late; status ops never change it
// - flag bit is a latch driving the flag output pin
// - block bit set ignores interrupts; accepting one sets the bit
// - return-and-enable clears the block bit
// - three level bits count up on subroutine call, down on return
// - register load or change sets code: positive 01, zero 00, negative 10
// - compare is unsigned when compare select is one, signed otherwise
// - compare gives 01 greater, 00 equal, 10 less
// - normal ops never make code 11; explicit lower loads may
// - add and subtract put bit three carry or borrow into half carry
// - rotate with carry use loads half carry from result bit five
// - bank pick chooses bank of registers one to three; register zero shared
// - add and subtract always update flags; carry enters only with carry use
// - rotate without carry use touches only register and code; with it nine bits
// - flagged rotate sets overflow when sign bit changes
// - overflow when like-signed operands give unlike-signed result
// - carry set on add carry or subtract without borrow
// - subtract with borrow treats clear carry as pending borrow
// - address space is four pages of 8192 bytes, 15 bits
// - low 13 address bits drive the offset lines
// - top two bits drive the page lines
// - reset clears page latch; branches load it from target top bits
// - indirect non-branch operand access uses its own page once only
// - interrupt service forces page zero
`timescale 1ns/100ps
module sfpl_status #(
	parameter int unsigned LEVEL_BITS = 3
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic sense_pin_in,
	input wire sfpl_pkg::sfpl_alu_req_type alu_req_in,
	input wire logic alu_to_reg_in,
	input wire sfpl_pkg::sfpl_psw_op_type upper_op_in,
	input wire sfpl_pkg::sfpl_psw_op_type lower_op_in,
	input wire logic [7:0] psw_data_in,
	input wire logic int_request_in,
	input wire logic call_in,
	input wire logic return_in,
	input wire logic return_enable_in,
	input wire logic [14:0] addr_in,
	input wire logic addr_valid_in,
	input wire logic branch_in,
	input wire logic indirect_in,
	input wire logic [1:0] reg_sel_in,
	output logic [7:0] upper_status_byte_out,
	output logic [7:0] lower_status_byte_out,
	output logic flag_pin_out,
	output logic int_accept_out,
	output logic [7:0] alu_result_out,
	output logic [2:0] reg_index_out,
	output logic [LEVEL_BITS-1:0] return_level_out,
	output logic [12:0] offset_lines_out,
	output logic page_line_low_out,
	output logic page_line_high_out
);
	typedef struct packed {
		logic sense_meta;
		logic sense_sync;
		logic flag;
		logic interrupt_block_bit;
		logic [LEVEL_BITS-1:0] level;
		logic [7:0] lower;
		logic [7:0] result;
	} sfpl_core_state_type;

	sfpl_core_state_type state_q;
	sfpl_core_state_type state_d;
	sfpl_pkg::sfpl_alu_res_type alu_res;
	sfpl_pkg::sfpl_addr_type addr_bus;
	logic [7:0] upper_now;
	logic [7:0] upper_new;
	logic int_take;
	logic flags_from_alu;
	logic rotate_op;

	sfpl_alu u_alu (
		.req_in(alu_req_in),
		.carry_in(state_q.lower[sfpl_pkg::LOWER_CARRY_POS]),
		.carry_use_in(state_q.lower[sfpl_pkg::LOWER_WC_POS]),
		.unsigned_cmp_in(state_q.lower[sfpl_pkg::LOWER_CMP_POS]),
		.res_out(alu_res)
	);

	sfpl_addr_mux u_addr (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.addr_in(addr_in),
		.addr_valid_in(addr_valid_in),
		.branch_in(branch_in),
		.indirect_in(indirect_in),
		.int_service_in(int_take),
		.addr_out(addr_bus),
		.page_latch_out()
	);

	// reads see the synchronised pin level, two flops behind the pin
	always_comb
	begin
		upper_now = 8'h00;
		upper_now[sfpl_pkg::UPPER_SENSE_POS] = state_q.sense_sync;
		upper_now[sfpl_pkg::UPPER_FLAG_POS] = state_q.flag;
		upper_now[sfpl_pkg::UPPER_BLOCK_POS] = state_q.interrupt_block_bit;
		upper_now[LEVEL_BITS-1:0] = state_q.level;
	end

	assign rotate_op = (alu_req_in.op == sfpl_pkg::SFPL_OP_ROR)
		|| (alu_req_in.op == sfpl_pkg::SFPL_OP_ROL);
	assign flags_from_alu = (alu_req_in.op == sfpl_pkg::SFPL_OP_ADD)
		|| (alu_req_in.op == sfpl_pkg::SFPL_OP_SUB)
		|| (rotate_op && state_q.lower[sfpl_pkg::LOWER_WC_POS]);
	assign int_take = int_request_in && !state_q.interrupt_block_bit;

	always_comb
	begin
		state_d = state_q;
		state_d.sense_meta = sense_pin_in;
		state_d.sense_sync = state_q.sense_meta;
		case (upper_op_in)
			sfpl_pkg::SFPL_PSW_LOAD: upper_new = psw_data_in;
			sfpl_pkg::SFPL_PSW_PRESET: upper_new = upper_now | psw_data_in;
			sfpl_pkg::SFPL_PSW_CLEAR: upper_new = upper_now & ~psw_data_in;
			default: upper_new = upper_now;
		endcase
		// only flag, block and level bits are writable
		upper_new = (upper_new & sfpl_pkg::UPPER_WRITE_MASK)
			| (upper_now & ~sfpl_pkg::UPPER_WRITE_MASK);
		state_d.flag = upper_new[sfpl_pkg::UPPER_FLAG_POS];
		state_d.interrupt_block_bit = upper_new[sfpl_pkg::UPPER_BLOCK_POS];
		state_d.level = upper_new[LEVEL_BITS-1:0];
		if (call_in || int_take)
			state_d.level = state_d.level + 1'b1;
		else if (return_in || return_enable_in)
			state_d.level = state_d.level - 1'b1;
		if (return_enable_in)
			state_d.interrupt_block_bit = 1'b0;
		if (int_take)
			state_d.interrupt_block_bit = 1'b1;
		case (lower_op_in)
			sfpl_pkg::SFPL_PSW_LOAD: state_d.lower = psw_data_in;
			sfpl_pkg::SFPL_PSW_PRESET: state_d.lower = state_q.lower | psw_data_in;
			sfpl_pkg::SFPL_PSW_CLEAR: state_d.lower = state_q.lower & ~psw_data_in;
			default:
			begin
				if (alu_to_reg_in || alu_req_in.op == sfpl_pkg::SFPL_OP_CMP)
				begin
					state_d.lower[sfpl_pkg::LOWER_CC_HI_POS] = alu_res.cc[1];
					state_d.lower[sfpl_pkg::LOWER_CC_LO_POS] = alu_res.cc[0];
				end
				if (flags_from_alu)
				begin
					state_d.lower[sfpl_pkg::LOWER_HALF_POS] = alu_res.half;
					state_d.lower[sfpl_pkg::LOWER_OVF_POS] = alu_res.ovf;
					state_d.lower[sfpl_pkg::LOWER_CARRY_POS] = alu_res.carry;
				end
			end
		endcase
		if (alu_to_reg_in)
			state_d.result = alu_res.result;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			state_q <= '0;
			state_q.lower <= sfpl_pkg::LOWER_RESET;
		end
		else
			state_q <= state_d;
	end

	always_comb
	begin
		// register zero sits outside the banks, index 0
		reg_index_out = (reg_sel_in == 2'h0) ? 3'h0
			: {state_q.lower[sfpl_pkg::LOWER_BANK_POS], reg_sel_in};
	end

	assign upper_status_byte_out = upper_now;
	assign lower_status_byte_out = state_q.lower;
	assign flag_pin_out = state_q.flag;
	assign int_accept_out = int_take;
	assign alu_result_out = state_q.result;
	assign return_level_out = state_q.level;
	assign offset_lines_out = addr_bus.offset;
	assign page_line_low_out = addr_bus.page[0];
	assign page_line_high_out = addr_bus.page[1];
endmodule : sfpl_status

// ### tb/sfpl_mem_model.sv
// behavioural external memory seen through the offset and page lines
`timescale 1ns/100ps
module sfpl_mem_model (
	input wire logic [12:0] offset_lines_in,
	input wire logic page_line_low_in,
	input wire logic page_line_high_in,
	output logic [7:0] data_out
);
	// content is a function of the page lines and offset bits 5:0, so a wrong page shows up
	assign data_out = {page_line_high_in, page_line_low_in, offset_lines_in[5:0]};
endmodule : sfpl_mem_model

// ### tb/sfpl_status_sva.sv
// port-level assertions for the status word and page latch block
`timescale 1ns/100ps
module sfpl_status_sva #(
	parameter int unsigned LEVEL_BITS = 3
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic sense_pin_in,
	input wire sfpl_pkg::sfpl_alu_req_type alu_req_in,
	input wire logic alu_to_reg_in,
	input wire sfpl_pkg::sfpl_psw_op_type upper_op_in,
	input wire sfpl_pkg::sfpl_psw_op_type lower_op_in,
	input wire logic call_in,
	input wire logic return_in,
	input wire logic return_enable_in,
	input wire logic [14:0] addr_in,
	input wire logic addr_valid_in,
	input wire logic branch_in,
	input wire logic indirect_in,
	input wire logic [7:0] upper_status_byte_out,
	input wire logic [7:0] lower_status_byte_out,
	input wire logic flag_pin_out,
	input wire logic int_accept_out,
	input wire logic [7:0] alu_result_out,
	input wire logic [LEVEL_BITS-1:0] return_level_out,
	input wire logic [12:0] offset_lines_out,
	input wire logic page_line_low_out,
	input wire logic page_line_high_out
);
	wire [1:0] pg = {page_line_high_out, page_line_low_out};
	wire no_low = lower_op_in == sfpl_pkg::SFPL_PSW_NONE;
	wire no_up = upper_op_in == sfpl_pkg::SFPL_PSW_NONE;
	wire is_cmp = alu_req_in.op == sfpl_pkg::SFPL_OP_CMP;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// the pin passes two sync flops, so only a steady pin is compared
	property p_sense;
		!$past(rst_in, 2) && $past(sense_pin_in) == sense_pin_in
			&& $past(sense_pin_in, 2) == sense_pin_in |-> upper_status_byte_out[7] == sense_pin_in;
	endproperty
	a_sense: assert property (p_sense) else $error("sense bit differs from pin");
	property p_flag;
		flag_pin_out == upper_status_byte_out[6];
	endproperty
	a_flag: assert property (p_flag) else $error("flag pin differs from flag bit");
	property p_unused;
		upper_status_byte_out[4:3] == 2'h0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused upper bits not zero");
	property p_block;
		(upper_status_byte_out[5] |-> !int_accept_out)
			and (int_accept_out |=> upper_status_byte_out[5]);
	endproperty
	a_block: assert property (p_block) else $error("interrupt block misbehaves");
	property p_reten;
		return_enable_in && !int_accept_out |=> !upper_status_byte_out[5];
	endproperty
	a_reten: assert property (p_reten) else $error("block bit not cleared");
	property p_up;
		(call_in ^ int_accept_out) && !return_in && no_up
			|=> return_level_out == LEVEL_BITS'($past(return_level_out) + 1);
	endproperty
	a_up: assert property (p_up) else $error("level did not count up");
	property p_down;
		return_in && !call_in && !int_accept_out && no_up
			|=> return_level_out == LEVEL_BITS'($past(return_level_out) - 1);
	endproperty
	a_down: assert property (p_down) else $error("level did not count down");
	property p_cc;
		alu_to_reg_in && !is_cmp && alu_req_in.op != sfpl_pkg::SFPL_OP_NONE && no_low
			|=> lower_status_byte_out[7:6] == (alu_result_out == 8'h00 ? 2'h0
			: alu_result_out[7] ? 2'h2 : 2'h1);
	endproperty
	a_cc: assert property (p_cc) else $error("code does not match result");
	property p_no11;
		no_low && (alu_to_reg_in || is_cmp) |=> lower_status_byte_out[7:6] != 2'h3;
	endproperty
	a_no11: assert property (p_no11) else $error("normal op gave code three");
	property p_offset;
		addr_valid_in |=> offset_lines_out == $past(addr_in[12:0]);
	endproperty
	a_offset: assert property (p_offset) else $error("offset lines wrong");
	property p_ind;
		addr_valid_in && (indirect_in || branch_in && !int_accept_out) |=> pg == $past(addr_in[14:13]);
	endproperty
	a_ind: assert property (p_ind) else $error("page lines wrong after access");
	property p_int_page;
		int_accept_out && !addr_valid_in |=> pg == 2'h0;
	endproperty
	a_int_page: assert property (p_int_page) else $error("interrupt left page nonzero");
	c_accept: cover property (int_accept_out);
	c_ind: cover property (addr_valid_in && indirect_in);
	c_cc3: cover property (lower_status_byte_out[7:6] == 2'h3);
endmodule : sfpl_status_sva

// ### tb/sfpl_status_tb_top.sv
// self-checking bench for the status word and page latch block
`timescale 1ns/100ps
module status_flags_and_page_latch_tb_top;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic sense_pin_in = 1'b0;
	sfpl_pkg::sfpl_alu_req_type alu_req_in;
	sfpl_pkg::sfpl_psw_op_type upper_op_in, lower_op_in;
	logic alu_to_reg_in, int_request_in, call_in, return_in, return_enable_in;
	logic addr_valid_in, branch_in, indirect_in, flag_pin_out, int_accept_out;
	logic page_line_low_out, page_line_high_out;
	logic [7:0] psw_data_in, upper_status_byte_out, lower_status_byte_out, alu_result_out, md;
	logic [14:0] addr_in;
	logic [1:0] reg_sel_in;
	logic [2:0] reg_index_out, return_level_out;
	logic [12:0] offset_lines_out;
	int failures = 0;
	int tests_run = 0;
	// op, a, b, lower before, result, lower after
	logic [43:0] tbl [15] = '{44'h27c4000bc84, 44'h2ff01000021, 44'h20101090348,
		44'h20101010240, 44'h30503000261, 44'h30503080169, 44'h31001000f41,
		44'h381ff008280, 44'h6810009034d, 44'h6400008808c, 44'h5400009a0ac,
		44'h48001000080, 44'h48001020040, 44'h40505020000, 44'h57f0001bf81};
	sfpl_status uut (.*);
	sfpl_mem_model mem (.offset_lines_in(offset_lines_out), .page_line_low_in(page_line_low_out),
		.page_line_high_in(page_line_high_out), .data_out(md));
	always #50 ref_clk_in = ~ref_clk_in;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	task automatic clr;
		alu_req_in = '0;
		upper_op_in = sfpl_pkg::SFPL_PSW_NONE;
		lower_op_in = sfpl_pkg::SFPL_PSW_NONE;
		{alu_to_reg_in, int_request_in, call_in, return_in, return_enable_in} = '0;
		{addr_valid_in, branch_in, indirect_in, psw_data_in, addr_in, reg_sel_in} = '0;
	endtask : clr
	// every request lasts exactly one clock, then pulses drop at the next falling edge
	task automatic tick;
		@(negedge ref_clk_in);
		clr;
	endtask : tick
	task automatic st(input sfpl_pkg::sfpl_psw_op_type u, l, input logic [7:0] d);
		upper_op_in = u;
		lower_op_in = l;
		psw_data_in = d;
		tick;
	endtask : st
	task automatic acc(input logic [14:0] a, input logic b, i);
		{addr_in, addr_valid_in, branch_in, indirect_in} = {a, 1'b1, b, i};
		tick;
	endtask : acc
	initial
	begin
		clr;
		repeat (2) @(negedge ref_clk_in);
		rst_in = 1'b0;
		chk({upper_status_byte_out[6:0], lower_status_byte_out}, 16'h0000);
		chk({page_line_high_out, page_line_low_out, offset_lines_out}, 16'h0000);
		st(sfpl_pkg::SFPL_PSW_LOAD, sfpl_pkg::SFPL_PSW_LOAD, 8'h3f);
		st(sfpl_pkg::SFPL_PSW_NONE, sfpl_pkg::SFPL_PSW_PRESET, 8'hc0);
		chk({upper_status_byte_out[6:0], lower_status_byte_out}, 16'h27ff);
		int_request_in = 1'b1;
		#1 chk(int_accept_out, 1'b0);
		tick;
		st(sfpl_pkg::SFPL_PSW_CLEAR, sfpl_pkg::SFPL_PSW_NONE, 8'hff);
		sense_pin_in = 1'b1;
		repeat (3) tick;
		st(sfpl_pkg::SFPL_PSW_LOAD, sfpl_pkg::SFPL_PSW_NONE, 8'h00);
		st(sfpl_pkg::SFPL_PSW_PRESET, sfpl_pkg::SFPL_PSW_NONE, 8'h58);
		chk({upper_status_byte_out, flag_pin_out}, 9'h181);
		st(sfpl_pkg::SFPL_PSW_CLEAR, sfpl_pkg::SFPL_PSW_NONE, 8'hff);
		chk(upper_status_byte_out, 8'h80);
		for (int k = 1; k <= 8; k++)
		begin
			call_in = 1'b1;
			tick;
			chk(return_level_out, k[2:0]);
		end
		return_in = 1'b1;
		tick;
		chk(return_level_out, 3'h7);
		acc(15'h4000, 1'b1, 1'b0);
		chk({page_line_high_out, page_line_low_out, offset_lines_out, md}, 23'h400080);
		acc(15'h6001, 1'b0, 1'b1);
		chk({page_line_high_out, page_line_low_out, offset_lines_out, md}, 23'h6001c1);
		tick;
		chk({page_line_high_out, page_line_low_out}, 2'h2);
		acc(15'h0123, 1'b0, 1'b0);
		chk({page_line_high_out, page_line_low_out, offset_lines_out, md}, 23'h4123a3);
		int_request_in = 1'b1;
		#1 chk(int_accept_out, 1'b1);
		tick;
		chk({upper_status_byte_out[5], return_level_out, page_line_high_out, page_line_low_out}, 6'h20);
		{return_in, return_enable_in} = 2'h3;
		tick;
		chk({upper_status_byte_out[5], return_level_out}, 4'h7);
		for (int b = 0; b < 2; b++)
			for (int s = 0; s < 4; s++)
			begin
				st(sfpl_pkg::SFPL_PSW_NONE, sfpl_pkg::SFPL_PSW_LOAD, {3'h0, b[0], 4'h0});
				reg_sel_in = s[1:0];
				#1 chk(reg_index_out, s == 0 ? 3'h0 : {b[0], s[1:0]});
			end
		foreach (tbl[i])
		begin
			st(sfpl_pkg::SFPL_PSW_NONE, sfpl_pkg::SFPL_PSW_LOAD, tbl[i][23:16]);
			alu_req_in = {tbl[i][43:40], tbl[i][39:24]};
			alu_to_reg_in = tbl[i][43:40] != 4'h4;
			tick;
			if (alu_to_reg_in === 1'b0 && tbl[i][43:40] == 4'h4)
				chk(lower_status_byte_out[7:6], tbl[i][7:6]);
			else
				chk({alu_result_out, lower_status_byte_out}, tbl[i][15:0]);
		end
		results;
	end
	initial
	begin
		#300000;
		failures++;
		results;
	end
endmodule : status_flags_and_page_latch_tb_top
bind sfpl_status sfpl_status_sva #(.LEVEL_BITS(LEVEL_BITS)) sva_i (.*);
